// >>> config_clock_gen.sv
`timescale 1ns/1ps
`default_nettype none
// divides the system clock down to the flash clock, never above its ceiling
module config_clock_gen
    import pflash_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    config_tick_if.gen tick
);
    typedef struct packed {
        logic [HALF_CNT_W-1:0] cnt; // cycles spent in this half period
        logic level;
        logic rise;
    } gen_s;

    gen_s s_reg;
    gen_s s_next;

    // toggle every half period; the clock free-runs from reset on
    always_comb begin
        s_next = s_reg;
        s_next.rise = 1'b0;
        if (s_reg.cnt == HALF_CNT_W'(CONFIG_HALF_CYCLES - 1)) begin
            s_next.cnt = '0;
            s_next.level = ~s_reg.level;
            s_next.rise = ~s_reg.level;
        end else begin
            s_next.cnt = s_reg.cnt + HALF_CNT_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick.level = s_reg.level;
    assign tick.rise = s_reg.rise;

    // high phase lasts exactly two system cycles, giving a 12.5 MHz flash clock
    a_clock_high_time: assert property (@(posedge clk) disable iff (rst)
        $rose(s_reg.level) |=> s_reg.level ##1 !s_reg.level)
        else $error("flash clock high phase has the wrong length");
    // rise marker sits on the first high cycle only
    a_rise_marker: assert property (@(posedge clk) disable iff (rst)
        s_reg.rise |-> $rose(s_reg.level))
        else $error("rise marker out of step with flash clock");
endmodule : config_clock_gen
`default_nettype wire

// >>> config_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
// flash clock level and its rising-edge marker, shared by generator and loader
interface config_tick_if;
    logic level; // current level of the flash clock
    logic rise; // high in the first system cycle of each high phase
    modport gen (output level, output rise);
    modport user (input level, input rise);
endinterface : config_tick_if
`default_nettype wire

// >>> flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural parallel nor flash: async writes, sync burst reads
module flash_model
    import pflash_cfg_pkg::*;
#(
    parameter int LATENCY = 3 // clock rises from read enable to first word
) (
    input wire logic config_clock,
    input wire logic hard_reset_n,
    input wire logic select_n,
    input wire logic read_enable_n,
    input wire logic addr_valid_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [ADDR_W-1:0] word_address, // no extra line
    input wire logic [DATA_W-1:0] data_from_dev,
    input wire logic data_oe,
    output logic [DATA_W-1:0] data_to_dev
);
    logic [DATA_W-1:0] mem [0:255]; // content, filled by the bench
    logic [DATA_W-1:0] wr_q [$]; // words written since hard reset
    logic [ADDR_W-1:0] burst_addr; // running burst address
    logic [ADDR_W-1:0] first_addr; // address loaded by the strobe
    logic [DATA_W-1:0] drv = '0; // value on the data pins
    logic sync_mode = 1'b0; // async until the mode write lands
    int lat_cnt; // rises since the burst began
    int reset_pulses = 0; // hard reset pulses seen

    // hard reset drops back to asynchronous mode
    always @(negedge hard_reset_n) begin
        wr_q.delete();
        sync_mode = 1'b0;
        reset_pulses++;
    end

    // writes land on the rising edge of the write strobe
    always @(posedge write_strobe_n) begin
        if (!select_n && data_oe && hard_reset_n) begin
            wr_q.push_back(data_from_dev);
            sync_mode = (wr_q.size() >= 2);
        end
    end

    // all read timing follows the device's flash clock
    always @(posedge config_clock) begin
        if (!select_n && !addr_valid_strobe_n) begin
            burst_addr = word_address;
            first_addr = word_address;
            lat_cnt = 0;
        end else if (!select_n && !read_enable_n && sync_mode) begin
            lat_cnt++;
            if (lat_cnt >= LATENCY) begin
                drv = mem[burst_addr[7:0]];
                burst_addr++;
            end else begin
                drv = ~drv; // junk while the latency runs
            end
        end
    end

    // released bus shows inverted junk, not the last word
    assign data_to_dev = (!select_n && !read_enable_n && hard_reset_n) ?
        drv : ~drv;
endmodule : flash_model
`default_nettype wire

// >>> pflash_cfg_pkg.sv
package pflash_cfg_pkg;
    // system clock and the ceiling on the flash clock
    localparam int CLK_HZ = 50000000;
    localparam int CONFIG_CLOCK_MAX_HZ = 40000000;
    // least half period that keeps the flash clock at or under its ceiling
    localparam int CONFIG_HALF_MIN =
        (CLK_HZ + 2 * CONFIG_CLOCK_MAX_HZ - 1) / (2 * CONFIG_CLOCK_MAX_HZ);
    // two cycles per half period leave room for the two-stage pin sampler
    localparam int CONFIG_HALF_CYCLES =
        (CONFIG_HALF_MIN < 2) ? 2 : CONFIG_HALF_MIN;
    localparam int HALF_CNT_W = 4;

    // least low time of the restart pin before the bus is given up
    localparam int RESTART_MIN_NS = 500;
    localparam int RESTART_MIN_CYCLES =
        (RESTART_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int RESTART_CNT_W = 6;

    // flash bus geometry
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] START_WORD_ADDR = 24'h000000;
    localparam logic [DATA_W-1:0] BYTE_LANE_MASK = 16'h00FF;

    // flash clock periods spent in each fixed step
    localparam logic [7:0] HARD_RESET_PERIODS = 8'h04;
    localparam logic [7:0] BURST_LATENCY_PERIODS = 8'h04;
    // system clocks after reset release before the straps are read
    localparam logic [7:0] STRAP_SETTLE_CYCLES = 8'h02;
    localparam int WRITE_CMDS = 2;

    // strap encodings of the scheme select pins
    localparam logic [1:0] ACTIVE_PARALLEL_SCHEME = 2'h1;
    localparam logic [1:0] FAST_PASSIVE_PARALLEL_SCHEME = 2'h2;
    localparam logic [1:0] ACTIVE_SERIAL_SCHEME = 2'h3;

    typedef enum logic [3:0] {
        ST_STRAP, ST_PASSIVE, ST_FLOAT, ST_HARD_RESET, ST_WR_SETUP,
        ST_WR_PULSE, ST_WR_HOLD, ST_ADDR, ST_LATENCY, ST_BURST,
        ST_WAIT_DONE, ST_USER
    } cfg_state_e;
endpackage : pflash_cfg_pkg

// >>> pflash_config_master.sv
// How it works
// - fetch configuration by continuous synchronous burst reads
// - timing comes from the internal oscillator clock
// - flash clock never runs above 40 MHz
// - drive a 24-bit word address
// - 16-bit shared data bus, flash drives under read enable
// - flash wait is ignored during configuration
// - flash starts asynchronous; writes are asynchronous cycles
// - sample synchronous data on flash clock rising edges
// - hard reset and select outputs are active low
// - read enable lets flash drive data and wait
// - pulse address valid low to load the address
// - write strobe low writes data words
// - generated flash clock times the whole interface
// - chain enable out goes low once own data taken
// - active parallel strap makes this device chain master
// - byte-wide or word-wide data toward chain slaves
// - address range covers 64 to 256 megabit flash
// - release done line; start together when it rises
// - restart low 500 ns resets and floats the bus
`timescale 1ns/1ps
`default_nettype none
module pflash_config_master
    import pflash_cfg_pkg::*;
#(
    parameter int CONFIG_WORDS = 1024, // words of this device's bitstream
    parameter logic [DATA_W-1:0] SYNC_MODE_CMD = 16'h0001, // arbitrary value
    parameter logic [DATA_W-1:0] SYNC_MODE_DATA = 16'h0002 // arbitrary value
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] scheme_select_pins,
    input wire logic word_wide_chain,
    input wire logic config_restart_n,
    input wire logic chain_enable_in_n,
    input wire logic config_complete_line_in,
    input wire logic flash_wait,
    input wire logic [DATA_W-1:0] flash_data_in,
    output logic config_clock,
    output logic flash_ctrl_oe,
    output logic flash_hard_reset_n,
    output logic flash_select_n,
    output logic flash_read_enable_n,
    output logic addr_valid_strobe_n,
    output logic flash_write_strobe_n,
    output logic [ADDR_W-1:0] flash_word_address,
    output logic [DATA_W-1:0] flash_data_out,
    output logic flash_data_oe,
    output logic chain_enable_out_n,
    output logic config_complete_line_out,
    output logic config_complete_line_oe,
    output logic [DATA_W-1:0] config_word,
    output logic config_word_valid,
    output logic user_mode,
    output logic user_flash_wait
);
    localparam logic [ADDR_W-1:0] LAST_WORD = ADDR_W'(CONFIG_WORDS - 1);

    // all loader state in one record
    typedef struct packed {
        cfg_state_e st;
        logic [RESTART_CNT_W-1:0] rcnt; // cycles restart has been low
        logic [7:0] wcnt; // flash clock periods left in a timed step, system clocks counted up in the strap step
        logic widx; // which of the two setup writes is in flight
        logic word_wide; // strap caught after reset release
        logic [ADDR_W-1:0] words; // words taken so far
        logic ctrl_oe;
        logic hard_reset_n;
        logic select_n;
        logic read_n;
        logic avd_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic doe;
        logic chain_out_n;
        logic done_oe;
        logic [DATA_W-1:0] word;
        logic valid;
        logic user;
        logic uwait;
    } loader_s;

    loader_s s_reg;
    loader_s s_next;

    // pins sampled into this domain
    logic [6:0] ctrl_q;
    logic [DATA_W-1:0] data_q;
    logic restart_q;
    logic ce_in_q;
    logic done_in_q;
    logic wait_q;
    logic [1:0] scheme_q;

    config_tick_if tick ();

    // flash clock from the internal oscillator domain
    config_clock_gen u_clock (
        .clk (clk),
        .rst (rst),
        .tick (tick)
    );

    pin_sync #(.WIDTH(7)) u_ctrl_sync (
        .clk (clk),
        .rst (rst),
        .d ({word_wide_chain, scheme_select_pins, flash_wait,
             config_complete_line_in, chain_enable_in_n, config_restart_n}),
        .q (ctrl_q)
    );

    pin_sync #(.WIDTH(DATA_W)) u_data_sync (
        .clk (clk),
        .rst (rst),
        .d (flash_data_in),
        .q (data_q)
    );

    assign restart_q = ctrl_q[0];
    assign ce_in_q = ctrl_q[1];
    assign done_in_q = ctrl_q[2];
    assign wait_q = ctrl_q[3];
    assign scheme_q = ctrl_q[5:4];

    // next state of the loader; timed steps after the strap read move only on flash clock rises
    always_comb begin
        s_next = s_reg;
        s_next.valid = 1'b0;
        // wait only reaches user logic once configuration is over
        s_next.uwait = s_reg.user & wait_q;
        // restart low time, saturating at the threshold
        if (restart_q) begin
            s_next.rcnt = '0;
        end else if (s_reg.rcnt != RESTART_CNT_W'(RESTART_MIN_CYCLES)) begin
            s_next.rcnt = s_reg.rcnt + RESTART_CNT_W'(1);
        end
        case (s_reg.st)
            ST_STRAP: begin
                // samplers are cleared by reset, so let both stages refill
                s_next.wcnt = s_reg.wcnt + 8'h01;
                if (s_reg.wcnt == STRAP_SETTLE_CYCLES) begin
                    s_next.word_wide = ctrl_q[6];
                    if (scheme_q == ACTIVE_PARALLEL_SCHEME) begin
                        s_next.st = ST_FLOAT;
                    end else begin
                        s_next.st = ST_PASSIVE;
                    end
                end
            end
            ST_PASSIVE: begin
                // strapped as a chain slave: this block stays off the bus
                s_next.st = ST_PASSIVE;
            end
            ST_FLOAT: begin
                // bus released; start only when enabled and not restarting
                if (restart_q && !ce_in_q && tick.rise) begin
                    s_next.st = ST_HARD_RESET;
                    s_next.ctrl_oe = 1'b1;
                    s_next.hard_reset_n = 1'b0;
                    s_next.select_n = 1'b1;
                    s_next.read_n = 1'b1;
                    s_next.avd_n = 1'b1;
                    s_next.we_n = 1'b1;
                    s_next.done_oe = 1'b1; // hold done line low while loading
                    s_next.chain_out_n = 1'b1;
                    s_next.wcnt = HARD_RESET_PERIODS;
                    s_next.widx = 1'b0;
                    s_next.words = '0;
                end
            end
            ST_HARD_RESET: begin
                if (tick.rise) begin
                    if (s_reg.wcnt == 8'h01) begin
                        s_next.hard_reset_n = 1'b1;
                        s_next.st = ST_WR_SETUP;
                    end
                    s_next.wcnt = s_reg.wcnt - 8'h01;
                end
            end
            ST_WR_SETUP: begin
                // flash wakes in asynchronous read; switch it by two writes
                if (tick.rise) begin
                    s_next.select_n = 1'b0;
                    s_next.addr = START_WORD_ADDR;
                    s_next.dout = s_reg.widx ? SYNC_MODE_DATA : SYNC_MODE_CMD;
                    s_next.doe = 1'b1;
                    s_next.st = ST_WR_PULSE;
                end
            end
            ST_WR_PULSE: begin
                if (tick.rise) begin
                    s_next.we_n = 1'b0;
                    s_next.st = ST_WR_HOLD;
                end
            end
            ST_WR_HOLD: begin
                // data held one period past the strobe's rising edge
                if (tick.rise) begin
                    if (!s_reg.we_n) begin
                        s_next.we_n = 1'b1;
                    end else begin
                        s_next.select_n = 1'b1;
                        s_next.doe = 1'b0;
                        s_next.widx = 1'b1;
                        s_next.st = s_reg.widx ? ST_ADDR : ST_WR_SETUP;
                    end
                end
            end
            ST_ADDR: begin
                // load the start address with one period of address valid
                if (tick.rise) begin
                    s_next.select_n = 1'b0;
                    s_next.avd_n = 1'b0;
                    s_next.addr = START_WORD_ADDR;
                    s_next.st = ST_LATENCY;
                    s_next.wcnt = BURST_LATENCY_PERIODS;
                end
            end
            ST_LATENCY: begin
                if (tick.rise) begin
                    s_next.avd_n = 1'b1;
                    s_next.read_n = 1'b0;
                    if (s_reg.wcnt == 8'h01) begin
                        s_next.st = ST_BURST;
                    end
                    s_next.wcnt = s_reg.wcnt - 8'h01;
                end
            end
            ST_BURST: begin
                // one word per flash clock rise, wait pin not consulted
                if (tick.rise) begin
                    s_next.word = s_reg.word_wide ? data_q
                                                  : (data_q & BYTE_LANE_MASK);
                    s_next.valid = 1'b1;
                    s_next.words = s_reg.words + ADDR_W'(1);
                    s_next.addr = s_reg.addr + ADDR_W'(1);
                    if (s_reg.words == LAST_WORD) begin
                        s_next.st = ST_WAIT_DONE;
                        s_next.select_n = 1'b1;
                        s_next.read_n = 1'b1;
                        s_next.chain_out_n = 1'b0;
                        s_next.done_oe = 1'b0;
                    end
                end
            end
            ST_WAIT_DONE: begin
                // all devices leave together once the shared line is high
                if (done_in_q) begin
                    s_next.st = ST_USER;
                    s_next.user = 1'b1;
                    s_next.ctrl_oe = 1'b0;
                end
            end
            ST_USER: begin
                s_next.st = ST_USER;
            end
            default: begin
                s_next.st = ST_FLOAT;
            end
        endcase
        // restart held long enough, or chain not enabled while restart is low: let go of the bus
        if ((s_reg.rcnt == RESTART_CNT_W'(RESTART_MIN_CYCLES) ||
             (ce_in_q && !restart_q)) && s_reg.st != ST_STRAP &&
            s_reg.st != ST_PASSIVE) begin
            s_next.st = ST_FLOAT;
            s_next.ctrl_oe = 1'b0;
            s_next.doe = 1'b0;
            s_next.select_n = 1'b1;
            s_next.read_n = 1'b1;
            s_next.avd_n = 1'b1;
            s_next.we_n = 1'b1;
            s_next.hard_reset_n = 1'b1;
            s_next.done_oe = 1'b0;
            s_next.chain_out_n = 1'b1;
            s_next.user = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '{st: ST_STRAP, hard_reset_n: 1'b1, select_n: 1'b1,
                       read_n: 1'b1, avd_n: 1'b1, we_n: 1'b1,
                       chain_out_n: 1'b1, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state record, apart from the flash clock and the tied-low done output
    assign config_clock = tick.level;
    assign flash_ctrl_oe = s_reg.ctrl_oe;
    assign flash_hard_reset_n = s_reg.hard_reset_n;
    assign flash_select_n = s_reg.select_n;
    assign flash_read_enable_n = s_reg.read_n;
    assign addr_valid_strobe_n = s_reg.avd_n;
    assign flash_write_strobe_n = s_reg.we_n;
    assign flash_word_address = s_reg.addr;
    assign flash_data_out = s_reg.dout;
    assign flash_data_oe = s_reg.doe;
    assign chain_enable_out_n = s_reg.chain_out_n;
    assign config_complete_line_out = 1'b0;
    assign config_complete_line_oe = s_reg.done_oe;
    assign config_word = s_reg.word;
    assign config_word_valid = s_reg.valid;
    assign user_mode = s_reg.user;
    assign user_flash_wait = s_reg.uwait;

    // address valid is low for exactly one flash clock period
    sequence avd_one_period;
        !s_reg.avd_n [*4] ##1 s_reg.avd_n;
    endsequence
    a_avd_pulse_len: assert property (@(posedge clk) disable iff (rst)
        $fell(s_reg.avd_n) |-> avd_one_period)
        else $error("address valid pulse is not one period");
    // never drive data while the flash may drive it
    a_no_bus_fight: assert property (@(posedge clk) disable iff (rst)
        !s_reg.read_n |-> !s_reg.doe)
        else $error("data driven while flash read is enabled");
    // writes are plain strobes with read disabled and data driven
    a_write_async: assert property (@(posedge clk) disable iff (rst)
        !s_reg.we_n |-> s_reg.read_n && s_reg.doe && !s_reg.select_n)
        else $error("write strobe without a proper write cycle");
    // restart held the full time gives up every drive next cycle
    a_restart_float: assert property (@(posedge clk) disable iff (rst)
        s_reg.rcnt == RESTART_CNT_W'(RESTART_MIN_CYCLES) &&
        s_reg.st != ST_PASSIVE |=> !s_reg.ctrl_oe && !s_reg.doe)
        else $error("bus not released after restart");
    // chain enable out falls only when the last word was taken
    a_chain_handoff: assert property (@(posedge clk) disable iff (rst)
        $fell(s_reg.chain_out_n) |-> s_reg.words == ADDR_W'(CONFIG_WORDS)
        && s_reg.valid && !s_reg.done_oe)
        else $error("chain enable out fell early");
    // consecutive words come from consecutive addresses
    sequence word_taken;
        s_reg.valid && s_reg.st == ST_BURST;
    endsequence
    a_addr_advance: assert property (@(posedge clk) disable iff (rst)
        word_taken |-> s_reg.addr == $past(s_reg.addr) + ADDR_W'(1))
        else $error("address did not advance by one word");
    // hard reset low keeps the flash deselected
    a_reset_deselect: assert property (@(posedge clk) disable iff (rst)
        !s_reg.hard_reset_n |-> s_reg.select_n && s_reg.read_n)
        else $error("flash selected during hard reset");
    // done line released during the wait
    a_done_release: assert property (@(posedge clk) disable iff (rst)
        s_reg.st == ST_WAIT_DONE |-> !s_reg.done_oe)
        else $error("done line held during the wait");
    // user mode follows a high done line unless the bus is given up
    a_user_entry: assert property (@(posedge clk) disable iff (rst)
        s_reg.st == ST_WAIT_DONE && done_in_q && !ce_in_q &&
        s_reg.rcnt != RESTART_CNT_W'(RESTART_MIN_CYCLES) |=> s_reg.user)
        else $error("user mode not entered");
endmodule : pflash_config_master
`default_nettype wire

// >>> pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage sampler for pins arriving from outside the clock domain
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] first; // read only by the second stage
        logic [WIDTH-1:0] second;
    } sync_s;

    sync_s s_reg;
    sync_s s_next;

    // shift one stage per edge
    always_comb begin
        s_next.first = d;
        s_next.second = s_reg.first;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.second;
endmodule : pin_sync
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pflash_cfg_pkg::*;
    localparam int WORDS = 8; // short bitstream keeps the run brief
    localparam logic [DATA_W-1:0] CMD = 16'h00A5; // arbitrary mode word
    localparam logic [DATA_W-1:0] DAT = 16'h5A01; // arbitrary mode data
    logic clk, rst, word_wide, restart_n, chain_in_n, wait_pin, other_low;
    logic rand_wait;
    logic [1:0] scheme;
    logic [DATA_W-1:0] fdata, dout, cword;
    logic [ADDR_W-1:0] addr;
    logic cclk, ctrl_oe, hrst_n, sel_n, rd_n, avd_n, we_n, doe, ceo_n;
    logic done_out, done_oe, cvalid, umode, uwait;
    wire logic done_line;
    logic [DATA_W-1:0] exp_mem [0:255]; // reference content
    logic [DATA_W-1:0] got_q [$]; // words delivered by the loader
    logic [31:0] seed = 32'h104F;
    logic [31:0] wseed = 32'h104F;
    int num_errors = 0;
    int checks_done = 0;
    realtime last_rise = 0;

    // open-drain done line with pull-up; another device may hold it low
    assign done_line = !((done_oe && !done_out) || other_low);

    pflash_config_master #(.CONFIG_WORDS(WORDS), .SYNC_MODE_CMD(CMD),
        .SYNC_MODE_DATA(DAT)) dut (.clk(clk), .rst(rst),
        .scheme_select_pins(scheme), .word_wide_chain(word_wide),
        .config_restart_n(restart_n), .chain_enable_in_n(chain_in_n),
        .config_complete_line_in(done_line), .flash_wait(wait_pin),
        .flash_data_in(fdata), .config_clock(cclk), .flash_ctrl_oe(ctrl_oe),
        .flash_hard_reset_n(hrst_n), .flash_select_n(sel_n),
        .flash_read_enable_n(rd_n), .addr_valid_strobe_n(avd_n),
        .flash_write_strobe_n(we_n), .flash_word_address(addr),
        .flash_data_out(dout), .flash_data_oe(doe),
        .chain_enable_out_n(ceo_n), .config_complete_line_out(done_out),
        .config_complete_line_oe(done_oe), .config_word(cword),
        .config_word_valid(cvalid), .user_mode(umode),
        .user_flash_wait(uwait));

    flash_model flash (.config_clock(cclk), .hard_reset_n(hrst_n),
        .select_n(sel_n), .read_enable_n(rd_n), .addr_valid_strobe_n(avd_n),
        .write_strobe_n(we_n), .word_address(addr), .data_from_dev(dout),
        .data_oe(doe), .data_to_dev(fdata));

    // 50 MHz system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks_done %0d num_errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    // bounded wait; running out is a failure and ends the run
    task automatic wait_for(ref logic sig, input logic val, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge clk);
            if (sig === val) return;
        end
        num_errors++;
        $display("ERROR %0t: wait ran out", $time);
        report_and_stop();
    endtask : wait_for

    // reset with straps held stable, idle pin levels checked in reset
    task automatic do_reset(input logic [1:0] s, input logic ww);
        #2 rst = 1'b1;
        scheme = s;
        word_wide = ww;
        repeat (12) @(posedge clk);
        check({hrst_n, sel_n, rd_n, avd_n, we_n, ceo_n, ctrl_oe, doe},
            32'hFC);
        #2 rst = 1'b0;
    endtask : do_reset

    // one full load compared word by word with the reference
    task automatic run_cfg(input logic [DATA_W-1:0] lane); // lanes kept
        wait_for(ceo_n, 1'b0, 3000);
        // let the word collector take the last valid pulse first
        #2;
        check(flash.reset_pulses, 1);
        check(flash.wr_q.size(), 2);
        check(flash.wr_q[0], CMD);
        check(flash.wr_q[1], DAT);
        check(flash.first_addr, START_WORD_ADDR);
        check(got_q.size(), WORDS);
        for (int i = 0; i < WORDS; i++) begin
            check(got_q[i], exp_mem[i] & lane);
        end
        check(done_oe, 1'b0);
    endtask : run_cfg

    // words are taken on the edge after the valid pulse
    always @(posedge clk) begin
        if (cvalid === 1'b1) got_q.push_back(cword);
    end

    // random wait pin must have no effect on the load
    always @(posedge clk) begin
        #2;
        wseed = lfsr(wseed);
        if (rand_wait) wait_pin = wseed[0];
    end

    // flash clock period never under 25 ns
    always @(posedge cclk) begin
        if (last_rise > 0) begin
            check(($realtime - last_rise) >= 25.0, 1);
        end
        last_rise = $realtime;
    end

    initial begin
        static logic [1:0] passive [3] = '{2'h0, FAST_PASSIVE_PARALLEL_SCHEME,
            ACTIVE_SERIAL_SCHEME};
        rst = 1'b1;
        scheme = ACTIVE_PARALLEL_SCHEME;
        word_wide = 1'b1;
        restart_n = 1'b1;
        chain_in_n = 1'b0;
        other_low = 1'b1;
        wait_pin = 1'b0;
        rand_wait = 1'b1;
        for (int i = 0; i < 256; i++) begin
            seed = lfsr(seed);
            exp_mem[i] = seed[DATA_W-1:0];
            flash.mem[i] = seed[DATA_W-1:0];
        end
        // word-wide load while another device holds done low
        do_reset(ACTIVE_PARALLEL_SCHEME, 1'b1);
        run_cfg(16'hFFFF);
        repeat (20) @(posedge clk);
        check(umode, 1'b0);
        #2 other_low = 1'b0;
        wait_for(umode, 1'b1, 20);
        @(posedge clk);
        #2 check(ctrl_oe, 1'b0);
        // user logic sees the wait pin once configured
        rand_wait = 1'b0;
        wait_pin = 1'b1;
        repeat (6) @(posedge clk);
        check(uwait, 1'b1);
        #2 wait_pin = 1'b0;
        repeat (6) @(posedge clk);
        check(uwait, 1'b0);
        rand_wait = 1'b1;
        // byte-wide load: a short restart pulse is ignored, a full one aborts
        do_reset(ACTIVE_PARALLEL_SCHEME, 1'b0);
        wait_for(sel_n, 1'b0, 200);
        check(done_line, 1'b0);
        #2 restart_n = 1'b0;
        repeat (20) @(posedge clk);
        #2 restart_n = 1'b1;
        repeat (4) @(posedge clk);
        check(ctrl_oe, 1'b1);
        #2 restart_n = 1'b0;
        repeat (32) @(posedge clk);
        check({ctrl_oe, doe}, 0);
        #2 chain_in_n = 1'b1;
        repeat (4) @(posedge clk);
        #2 restart_n = 1'b1;
        repeat (40) @(posedge clk);
        check({ctrl_oe, doe}, 0);
        got_q.delete();
        flash.reset_pulses = 0;
        #2 chain_in_n = 1'b0;
        run_cfg(16'h00FF);
        // other straps leave the flash bus alone
        foreach (passive[k]) begin
            do_reset(passive[k], 1'b1);
            repeat (100) @(posedge clk);
            check({ctrl_oe, doe, ceo_n}, 1);
        end
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
